// File: logic/cfl_pkg.sv
// Purpose: Shared constants for the serial configuration loader and its targets
// Assumes: Loader clock clk at 40 MHz
// Notes:   Lane width is a two-bit code for 1, 2, 4 or 8 lanes
package cfl_pkg;
  localparam int          LANES_MAX        = 8;
  localparam logic [1:0]  LW_1             = 2'h0;
  localparam logic [1:0]  LW_2             = 2'h1;
  localparam logic [1:0]  LW_4             = 2'h2;
  localparam logic [1:0]  LW_8             = 2'h3;
  localparam logic [7:0]  MASK_1           = 8'h01;
  localparam logic [7:0]  MASK_2           = 8'h03;
  localparam logic [7:0]  MASK_4           = 8'h0f;
  localparam logic [7:0]  MASK_8           = 8'hff;
  localparam int          DONE_WAIT_ENH    = 64;
  localparam int          DONE_WAIT_CASC   = 16;
  localparam int          INIT_CYCLES      = 299;
  localparam int          RESET_TIMEOUT_US = 40;
  localparam int          CLK_MHZ          = 40;
  localparam int          RESET_CYCLES     = RESET_TIMEOUT_US * CLK_MHZ;
  localparam int          DIV_HALF         = 2;
  localparam int          GATE_HOLD        = 8;

  function automatic logic [7:0] cfl_lane_mask(input logic [1:0] w);
    unique case (w)
      LW_1:    cfl_lane_mask = MASK_1;
      LW_2:    cfl_lane_mask = MASK_2;
      LW_4:    cfl_lane_mask = MASK_4;
      LW_8:    cfl_lane_mask = MASK_8;
    endcase
  endfunction
endpackage

// File: logic/cfl_link_if.sv
// Purpose: Wires between the loader and one target
// Assumes: Open-drain lines are resolved here from the enables
// Notes:   A bench with several targets ANDs their line levels itself
`timescale 1ns/1ps
interface cfl_link_if;
  logic       serial_clk;
  logic [7:0] lane;
  logic       gate_oe;
  logic       status_oe;
  logic       done_oe;
  logic       status_line;
  logic       done_line;

  // Any driver low pulls the shared status line low
  assign status_line = ~(gate_oe | status_oe);
  assign done_line   = ~done_oe;

  modport loader (output serial_clk, lane, gate_oe, input status_line, done_line);
  modport target (input serial_clk, lane, status_line, done_line, output status_oe, done_oe);
endinterface

// File: logic/cfl_sync.sv
// Purpose: Two flip-flop level synchroniser
// Assumes: Input is a slow level from another domain
// Notes:   First stage feeds only the second
`timescale 1ns/1ps
module cfl_sync #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Level
  input  wire logic d,
  output logic      q
);
  logic meta_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= RST_VAL;
      q      <= RST_VAL;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule // cfl_sync

// File: logic/cfl_target.sv
// Purpose: Target end receiving a serial image on one lane
// Assumes: Loader keeps the serial clock running from reset onward
// Notes:   Link logic runs on serial_clk, error timing on clk
`timescale 1ns/1ps
module cfl_target import cfl_pkg::*; #(
  parameter int LANE       = 0,
  parameter int IMAGE_BITS = 64,
  parameter int RESET_CYC  = RESET_CYCLES,
  parameter int INIT_CYC   = INIT_CYCLES
) (
  // Clock and reset
  input  wire logic  clk,
  input  wire logic  rst,
  // Link
  cfl_link_if.target link,
  // Chain
  input  wire logic  chain_enable_in_low,
  output logic       chain_enable_out_low,
  // User side
  input  wire logic  inject_error,
  output logic       user_mode,
  output logic       error_seen
);
  typedef enum logic [1:0] {
    T_RESET = 2'h0,
    T_RECV  = 2'h1,
    T_INIT  = 2'h2,
    T_USER  = 2'h3
  } cfl_tstate_type;

  cfl_tstate_type t_state_q, t_state_d;
  logic [31:0]    bit_cnt_q, bit_cnt_d;
  logic [15:0]    init_cnt_q, init_cnt_d;
  logic           cfg_q, cfg_d;
  logic           ceo_q, ceo_d;
  logic           stat_s, done_s, ce_s, user_s, err_s;
  logic           err_pend_q, err_pend_d;
  logic [15:0]    rst_cnt_q, rst_cnt_d;
  logic           stat_oe_q, stat_oe_d;

  cfl_sync #(.RST_VAL(1'b0)) u_stat (.clk(link.serial_clk), .rst(rst), .d(link.status_line), .q(stat_s));
  cfl_sync #(.RST_VAL(1'b0)) u_done (.clk(link.serial_clk), .rst(rst), .d(link.done_line), .q(done_s));
  cfl_sync #(.RST_VAL(1'b1)) u_ce   (.clk(link.serial_clk), .rst(rst), .d(chain_enable_in_low), .q(ce_s));
  cfl_sync #(.RST_VAL(1'b0)) u_user (.clk(clk), .rst(rst), .d(t_state_q == T_USER), .q(user_s));
  cfl_sync #(.RST_VAL(1'b0)) u_err  (.clk(clk), .rst(rst), .d(inject_error), .q(err_s));

  // Link side: receive, then release done and pass the chain on
  always_comb begin
    t_state_d  = t_state_q;
    bit_cnt_d  = bit_cnt_q;
    init_cnt_d = init_cnt_q;
    cfg_d      = cfg_q;
    ceo_d      = ceo_q;
    unique case (t_state_q)
      T_RESET: begin
        if (stat_s) begin
          t_state_d = T_RECV;
        end
      end
      T_RECV: begin
        // Chained targets wait here until the one ahead is done
        if (!ce_s) begin
          bit_cnt_d = bit_cnt_q + 32'h1;
          if (bit_cnt_q == 32'(IMAGE_BITS - 1)) begin
            cfg_d     = 1'b1;
            ceo_d     = 1'b0;
            t_state_d = T_INIT;
          end
        end
      end
      T_INIT: begin
        // Shared done: all targets start user mode together
        if (done_s) begin
          init_cnt_d = init_cnt_q + 16'h1;
          if (init_cnt_q == 16'(INIT_CYC - 1)) begin
            t_state_d = T_USER;
          end
        end
      end
      T_USER: begin
      end
    endcase
    // A low status line from anyone resets this target
    if (!stat_s) begin
      t_state_d  = T_RESET;
      bit_cnt_d  = 32'h0;
      init_cnt_d = 16'h0;
      cfg_d      = 1'b0;
      ceo_d      = 1'b1;
    end
  end

  always_ff @(posedge link.serial_clk or posedge rst) begin
    if (rst) begin
      t_state_q  <= T_RESET;
      bit_cnt_q  <= 32'h0;
      init_cnt_q <= 16'h0;
      cfg_q      <= 1'b0;
      ceo_q      <= 1'b1;
    end else begin
      t_state_q  <= t_state_d;
      bit_cnt_q  <= bit_cnt_d;
      init_cnt_q <= init_cnt_d;
      cfg_q      <= cfg_d;
      ceo_q      <= ceo_d;
    end
  end

  // Error side: hold status low for the reset timeout, then release
  always_comb begin
    err_pend_d = err_pend_q;
    rst_cnt_d  = rst_cnt_q;
    stat_oe_d  = stat_oe_q;
    if (stat_oe_q) begin
      rst_cnt_d = rst_cnt_q + 16'h1;
      if (rst_cnt_q == 16'(RESET_CYC - 1)) begin
        stat_oe_d = 1'b0;
        rst_cnt_d = 16'h0;
      end
    end else if (err_s && !err_pend_q) begin
      stat_oe_d  = 1'b1;
      err_pend_d = 1'b1;
    end
    if (!err_s) begin
      err_pend_d = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      err_pend_q <= 1'b0;
      rst_cnt_q  <= 16'h0;
      stat_oe_q  <= 1'b0;
      error_seen <= 1'b0;
    end else begin
      err_pend_q <= err_pend_d;
      rst_cnt_q  <= rst_cnt_d;
      stat_oe_q  <= stat_oe_d;
      error_seen <= stat_oe_d;
    end
  end

  assign link.status_oe     = stat_oe_q;
  assign link.done_oe       = ~cfg_q;
  assign chain_enable_out_low = ceo_q;
  assign user_mode          = user_s;
endmodule // cfl_target

// File: logic/cfl_loader.sv
// What this block does
// - Lane widths 1, 2, 4, 8; one to eight targets
// - Three targets: four lanes, lane three unused
// - One lane may feed two chained targets
// - Lane storage is sum of chained images
// - Image is width times longest lane, padded
// - Pick width from target count
// - Broadcast: chain enables low, lane zero shared
// - Broadcast targets start and finish together
// - Master alone generates the serial clock
// - Done drives first select; cascade feeds next
// - After last data, drive cascade output low
// - Handoff completes within one serial cycle
// - Any error stops the whole chain
// - No done at end: pull gate low
// - Low gate resets every target via status
// - Wait 64 or 16 cycles for done
// - Autorestart once status released high
// - User mode 299 cycles after done
// - Finished chained target drives chain output low
//
// Purpose: Master loader streaming a stored image over 1 to 8 lanes
// Assumes: Image beats are written before select goes low
// Notes:   Serial clock is clk divided by two times DIV and runs always
`timescale 1ns/1ps
module cfl_loader import cfl_pkg::*; #(
  parameter int AW      = 10,
  parameter int DIV     = DIV_HALF,
  parameter bit CASCADE = 1'b0
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst,
  // Link
  cfl_link_if.loader         link,
  // Image store
  input  wire logic          img_wr,
  input  wire logic [AW-1:0] img_addr,
  input  wire logic [7:0]    img_data,
  input  wire logic [AW-1:0] img_len,
  // Configuration
  input  wire logic [1:0]    lane_width,
  input  wire logic          auto_restart,
  // Cascade
  input  wire logic          loader_select_low,
  output logic               next_loader_select_low,
  // Status
  output logic               busy,
  output logic               failed
);
  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_SEND = 3'h1,
    S_WAIT = 3'h2,
    S_GATE = 3'h3,
    S_HOLD = 3'h4,
    S_DONE = 3'h5,
    S_FAIL = 3'h6
  } cfl_lstate_type;

  localparam int WAIT_CYC = CASCADE ? DONE_WAIT_CASC : DONE_WAIT_ENH;

  // Each beat holds one bit per lane; unused lanes are masked off by lane_width on the way out
  logic [7:0]     mem [0:(1<<AW)-1];
  cfl_lstate_type st_q, st_d;
  logic [7:0]     div_q, div_d;
  logic           sclk_q, sclk_d;
  logic [AW-1:0]  addr_q, addr_d;
  logic [7:0]     lane_q, lane_d;
  logic [7:0]     cnt_q, cnt_d;
  logic           gate_q, gate_d;
  logic           casc_q, casc_d;
  logic           busy_q, busy_d;
  logic           fail_q, fail_d;
  logic           stat_s, done_s, sel_s;
  logic           tick, rise, fall;
  logic [7:0]     mask;

  cfl_sync #(.RST_VAL(1'b0)) u_stat (.clk(clk), .rst(rst), .d(link.status_line), .q(stat_s));
  cfl_sync #(.RST_VAL(1'b0)) u_done (.clk(clk), .rst(rst), .d(link.done_line), .q(done_s));
  cfl_sync #(.RST_VAL(1'b1)) u_sel  (.clk(clk), .rst(rst), .d(loader_select_low), .q(sel_s));

  always_ff @(posedge clk) begin
    if (img_wr) begin
      mem[img_addr] <= img_data;
    end
  end

  assign tick = (div_q == 8'(DIV - 1));
  assign rise = tick && !sclk_q;
  assign fall = tick && sclk_q;
  assign mask = cfl_lane_mask(lane_width);

  always_comb begin
    st_d   = st_q;
    div_d  = tick ? 8'h0 : div_q + 8'h1;
    sclk_d = tick ? ~sclk_q : sclk_q;
    addr_d = addr_q;
    lane_d = lane_q;
    cnt_d  = cnt_q;
    gate_d = gate_q;
    casc_d = casc_q;
    fail_d = fail_q;
    unique case (st_q)
      S_IDLE: begin
        // Select low comes from the shared done line held low by targets
        if (!sel_s && stat_s && fall) begin
          lane_d = mem[{AW{1'b0}}] & mask;
          addr_d = {{(AW-1){1'b0}}, 1'b1};
          st_d   = S_SEND;
        end
      end
      S_SEND: begin
        if (fall) begin
          // Every lane runs to img_len; shorter lanes carry padding
          if (addr_q == img_len) begin
            lane_d = 8'h0;
            casc_d = 1'b0;
            cnt_d  = 8'h0;
            st_d   = S_WAIT;
          end else begin
            lane_d = mem[addr_q] & mask;
            addr_d = addr_q + {{(AW-1){1'b0}}, 1'b1};
          end
        end
      end
      S_WAIT: begin
        if (done_s) begin
          st_d = S_DONE;
        end else if (rise) begin
          cnt_d = cnt_q + 8'h1;
          if (cnt_q == 8'(WAIT_CYC - 1)) begin
            gate_d = 1'b1;
            cnt_d  = 8'h0;
            st_d   = S_GATE;
          end
        end
      end
      S_GATE: begin
        // Gate low drags status low on every target and slave loader
        if (rise) begin
          cnt_d = cnt_q + 8'h1;
          if (cnt_q == 8'(GATE_HOLD - 1)) begin
            gate_d = 1'b0;
            st_d   = auto_restart ? S_HOLD : S_FAIL;
            fail_d = !auto_restart;
          end
        end
      end
      S_HOLD: begin
        // Targets release status after their reset timeout
        if (stat_s) begin
          casc_d = 1'b1;
          st_d   = S_IDLE;
        end
      end
      S_DONE: begin
      end
      S_FAIL: begin
      end
      default: begin
        st_d = S_IDLE;
      end
    endcase
    // A target error anywhere halts the stream for the whole chain
    if (!stat_s && (st_q == S_SEND || st_q == S_WAIT || st_q == S_DONE)) begin
      lane_d = 8'h0;
      casc_d = 1'b1;
      st_d   = auto_restart ? S_HOLD : S_FAIL;
      fail_d = !auto_restart;
    end
    busy_d = (st_d == S_SEND) || (st_d == S_WAIT) || (st_d == S_GATE);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q   <= S_IDLE;
      div_q  <= 8'h0;
      sclk_q <= 1'b0;
      addr_q <= {AW{1'b0}};
      lane_q <= 8'h0;
      cnt_q  <= 8'h0;
      gate_q <= 1'b0;
      casc_q <= 1'b1;
      busy_q <= 1'b0;
      fail_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      div_q  <= div_d;
      sclk_q <= sclk_d;
      addr_q <= addr_d;
      lane_q <= lane_d;
      cnt_q  <= cnt_d;
      gate_q <= gate_d;
      casc_q <= casc_d;
      busy_q <= busy_d;
      fail_q <= fail_d;
    end
  end

  // Cascade low is set on the same falling edge as the last bit ends
  assign next_loader_select_low = casc_q;
  assign link.serial_clk        = sclk_q;
  assign link.lane              = lane_q;
  assign link.gate_oe           = gate_q;
  assign busy                   = busy_q;
  assign failed                 = fail_q;
endmodule // cfl_loader

// File: bench/cfl_link_asserts.sv
// Purpose: Concurrent checks on the link between loader and target
// Assumes: Default divider, so the serial clock is clk divided by four
// Notes:   Repetition counts assume that divider and eight-cycle gate hold
`timescale 1ns/1ps
module cfl_link_asserts #(
  parameter int RESET_CYC = 20
) (
  // Clocks and reset
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       serial_clk,
  // Link
  input wire logic [7:0] lane,
  input wire logic       gate_oe,
  input wire logic       status_oe,
  input wire logic       done_oe,
  input wire logic       status_line,
  input wire logic       done_line
);
  logic [7:0]  quiet_q, quiet_d;
  logic [15:0] hold_q, hold_d;

  // Serial rises with all lanes idle since the last data bit, saturating
  always_comb begin
    quiet_d = (lane != 8'h00) ? 8'h00 : quiet_q + {7'h00, quiet_q != 8'hff};
  end
  always_ff @(posedge serial_clk or posedge rst) begin
    if (rst) quiet_q <= 8'h00;
    else quiet_q <= quiet_d;
  end
  always_comb begin
    hold_d = status_oe ? hold_q + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) hold_q <= 16'h0000;
    else hold_q <= hold_d;
  end

  sequence s_high;
    serial_clk [*2];
  endsequence
  sequence s_low;
    !serial_clk [*2];
  endsequence

  a_serial_period: assert property (@(posedge clk) disable iff (rst)
    $rose(serial_clk) |-> s_high ##1 s_low ##1 serial_clk) else $error("serial clock period wrong");
  a_lane_steps: assert property (@(posedge clk) disable iff (rst)
    !$fell(serial_clk) && status_line |-> $stable(lane)) else $error("lanes moved off the falling edge");
  a_stop_on_error: assert property (@(posedge clk) disable iff (rst)
    !status_line [*8] |-> lane == 8'h00) else $error("stream kept running in reset");
  a_error_clears_done: assert property (@(posedge clk) disable iff (rst)
    !status_line [*8] |-> !done_line) else $error("done high while chain in reset");
  a_status_hold: assert property (@(posedge clk) disable iff (rst)
    $fell(status_oe) |-> hold_q >= 16'(RESET_CYC - 1) && hold_q <= 16'(RESET_CYC + 1))
    else $error("status release time wrong");
  a_gate_hold: assert property (@(posedge serial_clk) disable iff (rst)
    $rose(gate_oe) |-> gate_oe [*8] ##1 !gate_oe) else $error("gate pulse length wrong");
  a_gate_late: assert property (@(posedge serial_clk) disable iff (rst)
    $rose(gate_oe) |-> !done_line && quiet_q >= 8'h3e) else $error("gate pulled too early");
  a_done_ends_stream: assert property (@(posedge clk) disable iff (rst)
    done_line [*4] |-> lane == 8'h00) else $error("data still sent after done");
endmodule // cfl_link_asserts

// File: bench/tb.sv
// Purpose: Self-checking bench joining loader and target over one link
// Assumes: Short target counts keep the run brief
// Notes:   Lane bytes are compared beat by beat with a queue model
`timescale 1ns/1ps
module tb import cfl_pkg::*; ();
  localparam int IMG = 16;
  localparam int RST_CYC = 20;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       img_wr = 1'b0;
  logic [9:0] img_addr = 10'h000;
  logic [7:0] img_data = 8'h00;
  logic [9:0] img_len = 10'h000;
  logic [1:0] lane_width = LW_1;
  logic       auto_restart = 1'b0;
  logic       sel_low;
  logic       chain_in_low = 1'b0;
  logic       inject_error = 1'b0;
  logic       next_sel_low, busy, failed, chain_out_low, user_mode, error_seen;
  int         num_errors = 0;
  int         checks = 0;
  int         cyc = 0;
  logic [7:0] q[$];

  cfl_link_if link ();
  // Targets hold done low while unconfigured, which selects the loader
  assign sel_low = link.done_line;
  cfl_loader u_cfl_loader (.clk(clk), .rst(rst), .link(link.loader), .img_wr(img_wr), .img_addr(img_addr),
    .img_data(img_data), .img_len(img_len), .lane_width(lane_width), .auto_restart(auto_restart),
    .loader_select_low(sel_low), .next_loader_select_low(next_sel_low), .busy(busy), .failed(failed));
  cfl_target #(.IMAGE_BITS(IMG), .RESET_CYC(RST_CYC), .INIT_CYC(5)) u_cfl_target (.clk(clk), .rst(rst),
    .link(link.target), .chain_enable_in_low(chain_in_low), .chain_enable_out_low(chain_out_low),
    .inject_error(inject_error), .user_mode(user_mode), .error_seen(error_seen));
  cfl_link_asserts #(.RESET_CYC(RST_CYC)) u_cfl_link_asserts (.clk(clk), .rst(rst),
    .serial_clk(link.serial_clk), .lane(link.lane), .gate_oe(link.gate_oe), .status_oe(link.status_oe),
    .done_oe(link.done_oe), .status_line(link.status_line), .done_line(link.done_line));

  always #12.5 clk = ~clk;

  // Ceiling is several times the expected run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk_lane(input logic [7:0] got, input logic [7:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp, input string m);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t %s got %b exp %b", $time, m, got, exp);
    end
  endtask

  // First and last beats carry a one on lane zero so the stream edges are visible
  // Image is written under reset so loader and target leave reset together
  task automatic reset_load(input int n);
    logic [7:0] v;
    rst <= 1'b1;
    q.delete();
    for (int i = 0; i < n; i++) begin
      v = 8'($urandom);
      if (i == 0 || i == n - 1) v[0] = 1'b1;
      q.push_back(v);
      @(posedge clk);
      img_wr <= 1'b1;
      img_addr <= 10'(i);
      img_data <= v;
    end
    @(posedge clk);
    img_wr <= 1'b0;
    img_len <= 10'(n);
    repeat (10) @(posedge clk);
    rst <= 1'b0;
  endtask

  task automatic watch(input int n);
    logic [7:0] m;
    int t;
    m = 8'((1 << (1 << lane_width)) - 1);
    t = 0;
    while (link.lane === 8'h00 && t < 100) begin
      @(posedge link.serial_clk);
      t++;
    end
    chk_flag(busy, 1'b1, "busy while sending");
    for (int i = 0; i < n; i++) begin
      chk_lane(link.lane, q[i] & m, "beat");
      @(posedge link.serial_clk);
    end
    chk_lane(link.lane, 8'h00, "lanes after last beat");
    chk_flag(next_sel_low, 1'b0, "handoff");
  endtask

  task automatic settle(input int n);
    for (int i = 0; i < n && user_mode !== 1'b1 && failed !== 1'b1; i++) @(posedge clk);
  endtask

  initial begin
    void'($urandom(32'h2eda46ae));
    for (int w = 0; w < 4; w++) begin
      lane_width <= 2'(w);
      reset_load(IMG);
      watch(IMG);
      settle(400);
      chk_flag(user_mode, 1'b1, "user mode");
      chk_flag(failed, 1'b0, "no failure");
      chk_flag(chain_out_low, 1'b1 ^ 1'b1, "chain passed on");
      chk_flag(busy, 1'b0, "idle after done");
      $display("width test %0d done", w);
    end
    // Target waits on an unfinished chain ahead, so done never rises
    lane_width <= LW_8;
    chain_in_low <= 1'b1;
    reset_load(8);
    watch(8);
    settle(800);
    chk_flag(failed, 1'b1, "failure flagged");
    chk_flag(user_mode, 1'b0, "no user mode");
    chk_flag(chain_out_low, 1'b1, "chain held");
    $display("missing done test done");
    auto_restart <= 1'b1;
    chain_in_low <= 1'b0;
    lane_width <= LW_2;
    reset_load(IMG);
    repeat (30) @(posedge clk);
    inject_error <= 1'b1;
    repeat (6) @(posedge clk);
    chk_flag(link.status_line, 1'b0, "status pulled low");
    chk_flag(error_seen, 1'b1, "error seen");
    inject_error <= 1'b0;
    for (int i = 0; i < 200 && link.status_line !== 1'b1; i++) @(posedge clk);
    watch(IMG);
    settle(400);
    chk_flag(user_mode, 1'b1, "restart completes");
    $display("error restart test done");
    complete_run();
  end
endmodule // tb
